// file: rtl/sdli_pkg.sv
// Shared constants and carrier types for the safety indicator lamp block.
// Assumes a single 25 MHz clock and an active-high asynchronous reset.
package sdli_pkg;

  // Clock rate in hertz.
  localparam int unsigned CLK_HZ = 25_000_000;

  // Flash half-period in milliseconds, and its length in clock cycles.
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

  // Least quiet time in milliseconds before outputs may return after an interlock.
  localparam int unsigned QUIET_MS = 1000;
  localparam int unsigned QUIET_CYC = (CLK_HZ / 1000) * QUIET_MS;

  // Number of safety-related input terminals and selector width.
  localparam int unsigned N_IN = 2;
  localparam int unsigned SEL_W = 8;

  // Width of the flash and quiet timer counters.
  localparam int unsigned CNT_W = 25;

  // Error and alert event flags raised by the surrounding safety logic.
  typedef struct packed {
    logic              supply_err;
    logic              general_err;
    logic              output_err;
    logic              ext_output_err;
    logic              start_cross;
    logic [N_IN-1:0]   input_cross;
    logic              sync_alert;
    logic              interlock_alert;
  } sdli_event_s;

  // Lamp drive group.
  typedef struct packed {
    logic            power;
    logic            state;
    logic            start;
    logic            error;
    logic [N_IN-1:0] inputs;
  } sdli_lamp_s;

  // Operating mode of the latched safe state.
  typedef enum logic [1:0] {
    SDLI_RUN,
    SDLI_ALERT,
    SDLI_LOCKED
  } sdli_mode_e;

endpackage

// file: rtl/sdli_sync.sv
// Two-flop synchroniser for a vector of pin levels.
// Assumes the pins are asynchronous to i_clock.
module sdli_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  // First stage, read only by the second stage.
  logic [W-1:0] meta_q;

  // Both stages clear to zero under reset.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

// file: rtl/sdli_top.sv
// Indicator lamp driver and safe-state latch for a safety relay module.
// Assumes event flags come from logic on i_clock; pins and selectors are asynchronous.
//
// Function
// - State lamp follows safety output activation.
// - Start lamp off, on, or flashing when waiting.
// - Each input lamp follows its input terminal.
// - Alert enters safe state, flashes error lamp.
// - Alert clears itself when cause is gone.
// - Sync timeout flashes input lamps alternately.
// - Interlock flashes inputs together; needs 1 s quiet.
// - Detected error latches safe state until power cycle.
// - Steady error lamp errors, flashing error lamp alerts.
// - Start cross circuit: steady error, flashing start.
// - Selector change while powered is configuration error.
module sdli_top (
  input  wire logic                      i_clock,
  input  wire logic                      i_rst,
  input  wire logic                      i_out_active,
  input  wire logic                      i_start_met,
  input  wire logic                      i_start_wait,
  input  wire logic [sdli_pkg::N_IN-1:0] i_in_pins,
  input  wire logic [sdli_pkg::SEL_W-1:0] i_selector,
  input  wire sdli_pkg::sdli_event_s     i_event,
  output logic                           o_safe_state,
  output logic                           o_outputs_allowed,
  output logic                           o_config_err,
  output logic [sdli_pkg::SEL_W-1:0]     o_active_sel,
  output sdli_pkg::sdli_lamp_s           o_lamp
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisation.

  // Synchronised input terminals and selector.
  logic [sdli_pkg::N_IN-1:0]  in_s;
  logic [sdli_pkg::SEL_W-1:0] sel_s;

  sdli_sync #(.W(sdli_pkg::N_IN + sdli_pkg::SEL_W)) u_sync (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_async ({i_in_pins, i_selector}),
    .o_sync  ({in_s, sel_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flash timebase.

  // Half-period counter and flash phase.
  logic [sdli_pkg::CNT_W-1:0] fl_cnt_q, fl_cnt_d;
  logic                       phase_q, phase_d;

  // Next values of the flash timebase.
  always_comb begin
    fl_cnt_d = fl_cnt_q + 1'b1;
    phase_d  = phase_q;
    if (fl_cnt_q == sdli_pkg::CNT_W'(sdli_pkg::FLASH_HALF_CYC - 1)) begin
      fl_cnt_d = '0;
      phase_d  = ~phase_q;
    end
  end

  // Register the flash timebase.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      fl_cnt_q <= '0;
      phase_q  <= 1'b0;
    end else begin
      fl_cnt_q <= fl_cnt_d;
      phase_q  <= phase_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Selector capture and configuration check.

  // Captured selector, capture flag and sticky configuration error.
  logic [sdli_pkg::SEL_W-1:0] sel_q, sel_d;
  logic                       cap_q, cap_d;
  logic                       cfg_q, cfg_d;
  logic [1:0]                 warm_q, warm_d;  // One fill flag per synchroniser stage.

  // The selector is caught once the synchroniser holds real pin levels, so the
  // reset zeros in its stages are never mistaken for a selector move.
  always_comb begin
    sel_d  = sel_q;
    warm_d = {warm_q[0], 1'b1};
    cap_d  = cap_q | warm_q[1];
    cfg_d  = cfg_q;
    if (!cap_q) begin
      sel_d = sel_s;
    end else if (sel_s != sel_q) begin
      cfg_d = 1'b1;
    end
  end

  // Register the selector state.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      sel_q  <= '0;
      warm_q <= '0;
      cap_q  <= 1'b0;
      cfg_q  <= 1'b0;
    end else begin
      sel_q  <= sel_d;
      warm_q <= warm_d;
      cap_q  <= cap_d;
      cfg_q  <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Safe-state mode and interlock quiet timer.

  // Any detected error; these latch until reset.
  logic det_err;
  assign det_err = i_event.supply_err | i_event.general_err | i_event.output_err
                 | i_event.ext_output_err | i_event.start_cross
                 | (|i_event.input_cross) | cfg_q;

  // Alert currently present.
  logic alert;
  assign alert = i_event.sync_alert | i_event.interlock_alert;

  // Mode, latched error kind, interlock pending and quiet counter.
  sdli_pkg::sdli_mode_e       mode_q, mode_d;
  sdli_pkg::sdli_event_s      err_q, err_d;
  logic                       cfg_seen_q, cfg_seen_d;
  logic                       ilk_q, ilk_d;
  logic [sdli_pkg::CNT_W-1:0] qt_q, qt_d;

  // Mode transitions; a detected error wins over everything and never leaves.
  always_comb begin
    mode_d     = mode_q;
    err_d      = err_q;
    cfg_seen_d = cfg_seen_q;
    ilk_d      = ilk_q | i_event.interlock_alert;
    qt_d       = qt_q;
    // Quiet timer runs only while both inputs are deactivated.
    if (|in_s || i_event.interlock_alert) begin
      qt_d = '0;
    end else if (qt_q != sdli_pkg::CNT_W'(sdli_pkg::QUIET_CYC)) begin
      qt_d = qt_q + 1'b1;
    end
    if (ilk_q && !i_event.interlock_alert
        && qt_q == sdli_pkg::CNT_W'(sdli_pkg::QUIET_CYC)) begin
      ilk_d = 1'b0;
    end
    unique case (mode_q)
      sdli_pkg::SDLI_RUN, sdli_pkg::SDLI_ALERT: begin
        if (det_err) begin
          mode_d     = sdli_pkg::SDLI_LOCKED;
          err_d      = i_event;
          cfg_seen_d = cfg_q;
        end else if (alert || ilk_d) begin
          mode_d = sdli_pkg::SDLI_ALERT;
        end else begin
          mode_d = sdli_pkg::SDLI_RUN;
        end
      end
      sdli_pkg::SDLI_LOCKED: begin
        mode_d     = sdli_pkg::SDLI_LOCKED;
        err_d      = err_q | i_event;
        cfg_seen_d = cfg_seen_q | cfg_q;
      end
      default: begin
        mode_d = sdli_pkg::SDLI_LOCKED;
      end
    endcase
  end

  // Register the mode state.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      mode_q     <= sdli_pkg::SDLI_RUN;
      err_q      <= '0;
      cfg_seen_q <= 1'b0;
      ilk_q      <= 1'b0;
      qt_q       <= '0;
    end else begin
      mode_q     <= mode_d;
      err_q      <= err_d;
      cfg_seen_q <= cfg_seen_d;
      ilk_q      <= ilk_d;
      qt_q       <= qt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lamp pattern selection.

  // Next lamp pattern and outputs.
  sdli_pkg::sdli_lamp_s lamp_d;
  logic                 safe_d;

  // Errors take the lamps over; alerts overlay a flashing error lamp.
  always_comb begin
    lamp_d        = '0;
    lamp_d.power  = 1'b1;
    lamp_d.state  = i_out_active & (mode_q == sdli_pkg::SDLI_RUN);
    lamp_d.start  = i_start_met | (i_start_wait & phase_q);
    lamp_d.inputs = in_s;
    safe_d        = (mode_q != sdli_pkg::SDLI_RUN);
    if (mode_q == sdli_pkg::SDLI_LOCKED) begin
      lamp_d.error  = 1'b1;
      lamp_d.state  = 1'b0;
      lamp_d.start  = 1'b0;
      lamp_d.inputs = '0;
      if (cfg_seen_q) begin
        lamp_d.state  = 1'b1;
        lamp_d.start  = 1'b1;
        lamp_d.inputs = '1;
      end else if (err_q.general_err) begin
        lamp_d.state  = phase_q;
        lamp_d.start  = phase_q;
        lamp_d.inputs = {sdli_pkg::N_IN{phase_q}};
      end else if (err_q.supply_err) begin
        lamp_d.power = phase_q;
      end else if (err_q.output_err) begin
        lamp_d.state = phase_q;
      end else if (err_q.ext_output_err) begin
        lamp_d.state = phase_q;
        lamp_d.start = phase_q;
      end else if (err_q.start_cross) begin
        lamp_d.start = phase_q;
      end else begin
        lamp_d.inputs = err_q.input_cross & {sdli_pkg::N_IN{phase_q}};
      end
    end else if (mode_q == sdli_pkg::SDLI_ALERT) begin
      lamp_d.error = phase_q;
      if (i_event.sync_alert) begin
        lamp_d.inputs = {phase_q, ~phase_q};
      end else begin
        lamp_d.inputs = {sdli_pkg::N_IN{phase_q}};
      end
    end
  end

  // Register every output.
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_lamp            <= '0;
      o_safe_state      <= 1'b1;
      o_outputs_allowed <= 1'b0;
      o_config_err      <= 1'b0;
      o_active_sel      <= '0;
    end else begin
      o_lamp            <= lamp_d;
      o_safe_state      <= safe_d;
      o_outputs_allowed <= ~safe_d;
      o_config_err      <= cfg_q;
      o_active_sel      <= sel_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  chk_lock_holds: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_LOCKED |=> mode_q == sdli_pkg::SDLI_LOCKED)
    else $error("locked safe state was released");
  chk_lock_error_lamp: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_LOCKED |=> o_lamp.error)
    else $error("error lamp not steady in locked state");
  chk_alert_safe: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_ALERT |=> o_safe_state && !o_outputs_allowed)
    else $error("alert did not force safe state");
  chk_alert_flash: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_ALERT |=> o_lamp.error == $past(phase_q))
    else $error("error lamp not flashing on alert");
  chk_alert_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_ALERT && !alert && !ilk_d && !det_err
    |=> mode_q == sdli_pkg::SDLI_RUN)
    else $error("alert did not clear");
  chk_sync_alt: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_ALERT && i_event.sync_alert
    |=> o_lamp.inputs[0] != o_lamp.inputs[1])
    else $error("sync alert lamps not alternate");
  chk_ilk_quiet: assert property (@(posedge i_clock) disable iff (i_rst)
    ilk_q && qt_q != sdli_pkg::CNT_W'(sdli_pkg::QUIET_CYC) |=> ilk_q)
    else $error("interlock released before quiet time");
  chk_state_lamp: assert property (@(posedge i_clock) disable iff (i_rst)
    mode_q == sdli_pkg::SDLI_RUN |=> o_lamp.state == $past(i_out_active))
    else $error("state lamp mismatch");
  chk_cfg_sticky: assert property (@(posedge i_clock) disable iff (i_rst)
    cap_q && sel_s != sel_q |=> cfg_q ##1 mode_q == sdli_pkg::SDLI_LOCKED)
    else $error("selector change not flagged");

  cov_alert: cover property (@(posedge i_clock) mode_q == sdli_pkg::SDLI_ALERT);
  cov_lock: cover property (@(posedge i_clock) mode_q == sdli_pkg::SDLI_LOCKED);
  cov_ilk_release: cover property (@(posedge i_clock) ilk_q ##1 !ilk_q);

endmodule

// file: tb/sdli_operator.sv
// Operator's view of the lamp group: which flash relations can be seen.
// Assumes the lamp levels come straight from the block on one clock.
module sdli_operator (
  input  wire sdli_pkg::sdli_lamp_s i_lamp,
  output logic                      o_alternate,
  output logic                      o_together
);
  ////////////////////////////////////////////////////////////////////////////
  // The operator sees input lamps in opposite phase, or in phase with error.
  always_comb begin
    o_alternate = (i_lamp.inputs[1] != i_lamp.inputs[0]);
    o_together  = (i_lamp.inputs[1] == i_lamp.inputs[0]) &&
                  (i_lamp.error == i_lamp.inputs[0]);
  end
endmodule

// file: tb/sdli_top_bench.sv
// Self-checking bench for the indicator lamp block.
// Assumes the flash phase does not toggle within the short run after a reset.
module sdli_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 i_clock = 1'b0;  // Clock, 40 ns period.
  logic                 rst     = 1'b1;  // Reset, active high.
  logic                 act     = 1'b0;  // Outputs activated.
  logic                 smet    = 1'b0;  // Start condition met.
  logic                 swait   = 1'b0;  // Waiting for start.
  logic [1:0]           pins    = 2'h0;  // Input terminals.
  logic [7:0]           sel     = 8'h00; // Selector position.
  sdli_pkg::sdli_event_s ev     = '0;    // Event flags.
  logic                 safe, allowed, cfg, alt, tog;
  logic [7:0]           asel;            // Captured selector.
  sdli_pkg::sdli_lamp_s lamp;            // Lamp levels.
  logic                 ph;              // Flash phase seen on the start lamp.
  int                   num_errors  = 0;
  int                   check_count = 0;
  logic [8:0]           ev_tab [7] = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h008, 9'h004};
  logic [5:0]           fl_tab [7] = '{6'h20, 6'h1B, 6'h10, 6'h18, 6'h08, 6'h02, 6'h01};

  sdli_top dut_u (.i_clock(i_clock), .i_rst(rst), .i_out_active(act), .i_start_met(smet),
    .i_start_wait(swait), .i_in_pins(pins), .i_selector(sel), .i_event(ev),
    .o_safe_state(safe), .o_outputs_allowed(allowed), .o_config_err(cfg),
    .o_active_sel(asel), .o_lamp(lamp));
  sdli_operator op_u (.i_lamp(lamp), .o_alternate(alt), .o_together(tog));

  ////////////////////////////////////////////////////////////////////////////
  // Clock generator.
  always #20 i_clock = ~i_clock;

  // Waits a number of falling edges, where inputs are changed.
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // Compares one value and counts it.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Power cycle with selector s; checks the reset levels and the capture.
  task automatic do_reset(input logic [7:0] s);
    @(negedge i_clock);
    rst = 1'b1;
    ev = '0; act = 1'b0; smet = 1'b0; swait = 1'b0; pins = 2'h0; sel = s;
    cyc(19);
    check(lamp, 6'h00);
    check({safe, allowed, cfg}, 3'h4);
    check(asel, 8'h00);
    rst = 1'b0;
    cyc(5);
    check({lamp.power, safe, allowed}, 3'h5);
    check(asel, s);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Steady lamps follow outputs, start and inputs; waiting start gives phase.
  task automatic steady_lamps;
    for (int i = 0; i < 4; i++) begin
      act = i[0]; smet = i[1]; pins = i[1:0];
      cyc(4);
      check(lamp.state, act);
      check(lamp.start, smet);
      check(lamp.inputs, pins);
    end
    smet = 1'b0; swait = 1'b1;
    cyc(4);
    ph = lamp.start;
    swait = 1'b0;
  endtask

  // Synchronisation alert: safe state, alternate inputs, exits when cleared.
  task automatic sync_alert;
    pins = 2'h3; ev.sync_alert = 1'b1;
    cyc(3);
    check({safe, allowed}, 2'h2);
    check({alt, lamp.error}, {1'b1, ph});
    ev = '0;
    cyc(3);
    check({safe, allowed, lamp.error}, 3'h2);
  endtask

  // Interlock: inputs flash with error; a short quiet time does not release.
  task automatic interlock;
    pins = 2'h3; ev.interlock_alert = 1'b1;
    cyc(3);
    check({tog, lamp.error, safe}, {1'b1, ph, 1'b1});
    ev = '0; pins = 2'h0;
    cyc(200);
    check({safe, allowed}, 2'h2);
  endtask

  // Each of the seven event-flag errors: steady error lamp, own lamps flashing, latched.
  task automatic detected_errors;
    for (int k = 0; k < 7; k++) begin
      do_reset(8'h5A);
      ev = ev_tab[k];
      cyc(3);
      check(lamp & (fl_tab[k] | 6'h04), (fl_tab[k] & {6{ph}}) | 6'h04);
      ev = '0;
      cyc(10);
      check({safe, allowed, lamp.error}, 3'h5);
    end
  endtask

  // Selector moved while powered: configuration error, old selector kept.
  task automatic selector_change;
    do_reset(8'h5A);
    sel = 8'hA5;
    cyc(8);
    check({cfg, safe, asel}, {2'h3, 8'h5A});
    check(lamp & 6'h1F, 6'h1F);
    do_reset(8'hA5);
    check(cfg, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    do_reset(8'h3C);
    steady_lamps();
    sync_alert();
    interlock();
    detected_errors();
    selector_change();
    wrap_up();
  end

  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge i_clock);
    num_errors++;
    wrap_up();
  end
endmodule
